// [sector_map_defaults.sv]
// Sector map tail descriptors and factory delivery state store
//
// Overview of operation
// [RL1] 64KB region size on the small device reads 00FFFFh, count-minus-one units
// [RL2] 64KB region on the large device covers 512 sectors, top size byte 01h
// [RL3] 64KB region descriptor sets only erase type 2, upper nibble Fh
// [RL4] 256KB header carries configuration id 05h and region count 00h
// [RL5] 256KB header low byte: bits 7:2 ones, map bit one, end bit one
// [RL6] 256KB header bits 31:24 read FFh
// [RL7] 256KB region size on the small device reads 00FFFFh
// [RL8] 256KB region size on the large device reads 01FFFFh
// [RL9] 256KB region descriptor sets only erase type 3
// [RL10] Main array delivered erased, every byte reads FFh
// [RL11] First 16 one-time bytes hold a random value, the rest FFh
// [RL12] Status one nonvolatile copy delivered as 00h
// [RL13] Configuration one nonvolatile copy delivered as 00h
// [RL14] Configuration two nonvolatile copy delivered as 08h
// [RL15] Configuration three nonvolatile copy delivered as 00h
// [RL16] Configuration four nonvolatile copy delivered as 10h
// [RL17] Password delivered with every bit one
// [RL18] Protection scheme register delivered as FFFFh
// [RL19] Every persistent sector lock bit delivered as one
`timescale 1ns/1ps
`include "sector_map_defaults_params.svh"

module sector_map_defaults
   import sector_map_defaults_pkg::*;
#(
   parameter bit     LARGE_DEVICE = 1'b0,
   parameter int     SECTORS      = 256,
   parameter int     OTP_BYTES    = 1024,
   parameter [127:0] OTP_SEED     = 128'h5A3C_96E1_0F7B_C248_1D6E_A935_77B0_4C2F
)(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   output logic             o_rvalid
);
   // OTP_SEED is an arbitrary stand-in for the factory random bytes
   localparam int LW = $clog2(SECTORS / 32) > 0 ? $clog2(SECTORS / 32) : 1;
   localparam int OW = $clog2(OTP_BYTES);

   // Refuse shapes the lock groups and one-time area cannot serve; both pointers
   // must cover their ranges exactly; all accepted shapes do but SECTORS of 32, whose one-bit lock pointer reaches an out-of-range group 1
   generate
      if (SECTORS < 32 || SECTORS % 32 != 0 || ((SECTORS / 32) & ((SECTORS / 32) - 1)) != 0
          || OTP_BYTES <= `OTP_RANDOM_BYTES || (OTP_BYTES & (OTP_BYTES - 1)) != 0) begin : g_bad
         $error("sector_map_defaults: unsupported SECTORS or OTP_BYTES");
      end
   endgenerate

   // Address decode shared by write and read paths
   function automatic reg_sel_t decode(input logic [7:0] a);
      case (a)
         `OFS_MAP64_REGION:  decode = SEL_MAP64;
         `OFS_MAP256_HDR:    decode = SEL_HDR256;
         `OFS_MAP256_REGION: decode = SEL_MAP256;
         `OFS_STATUS_ONE:    decode = SEL_STAT1;
         `OFS_CFG_ONE:       decode = SEL_CFG1;
         `OFS_CFG_TWO:       decode = SEL_CFG2;
         `OFS_CFG_THREE:     decode = SEL_CFG3;
         `OFS_CFG_FOUR:      decode = SEL_CFG4;
         `OFS_PASSWORD_LO:   decode = SEL_PASS_LO;
         `OFS_PASSWORD_HI:   decode = SEL_PASS_HI;
         `OFS_SCHEME:        decode = SEL_SCHEME;
         `OFS_LOCK_INDEX:    decode = SEL_LOCK_IDX;
         `OFS_LOCK_DATA:     decode = SEL_LOCK_DAT;
         `OFS_OTP_ADDR:      decode = SEL_OTP_ADDR;
         `OFS_OTP_DATA:      decode = SEL_OTP_DAT;
         `OFS_CONTROL:       decode = SEL_CTRL;
         `OFS_STATE:         decode = SEL_STATE;
         `OFS_ARRAY_DATA:    decode = SEL_ARRAY;
         default:            decode = SEL_NONE;
      endcase
   endfunction

   reg_sel_t           wsel;
   reg_sel_t           rsel;
   logic               restore;
   logic               lock_erase;
   word_t              map64_word;
   word_t              hdr256_word;
   word_t              map256_word;
   logic [23:0]        size_field;
   logic [3:0]         erase_t2_only;
   logic [3:0]         erase_t3_only;
   byte_t              status_one_nonvolatile_q;
   byte_t              cfg_one_q;
   byte_t              cfg_two_q;
   byte_t              cfg_three_q;
   byte_t              cfg_four_q;
   logic [63:0]        password_q;
   logic [15:0]        sector_protection_scheme_q;
   logic [SECTORS-1:0] persistent_sector_lock_bits_q;
   logic [LW-1:0]      lock_index_q;
   logic [OW-1:0]      otp_addr_q;
   byte_t              otp_q [OTP_BYTES];
   word_t              rdata_d;
   logic               otp_touched_q;
   logic               first_seen_q;

   assign wsel       = i_wr ? decode(i_addr) : SEL_NONE;
   assign rsel       = decode(i_addr);
   assign restore    = (wsel == SEL_CTRL) && i_wdata[`CTRL_RESTORE_BIT];
   assign lock_erase = (wsel == SEL_CTRL) && i_wdata[`CTRL_LOCK_ERASE];

   // Region size picked by density, shared by both uniform regions
   assign size_field = LARGE_DEVICE ? `SIZE_LARGE_DEV : `SIZE_SMALL_DEV; // RL1 RL2 RL7 RL8

   // Erase type support nibbles: one type per uniform region
   always_comb begin
      erase_t2_only = 4'h0;
      erase_t3_only = 4'h0;
      erase_t2_only[`ERASE_T2_BIT] = 1'b1; // RL3
      erase_t3_only[`ERASE_T3_BIT] = 1'b1; // RL9
   end

   // Fixed descriptor words of the map tail
   assign map64_word  = {size_field, `DESC_UPPER_NIB, erase_t2_only}; // RL1 RL2 RL3
   assign hdr256_word = {`HDR_RESERVED, `HDR_REGION_COUNT, `HDR_CONFIG_ID, // RL4 RL6
                         `HDR_LOW_RESERVED, 1'b1, 1'b1}; // RL5
   assign map256_word = {size_field, `DESC_UPPER_NIB, erase_t3_only}; // RL7 RL8 RL9

   // Nonvolatile register copies, delivered values on reset or restore
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         status_one_nonvolatile_q <= `RST_STATUS_ONE; // RL12
         cfg_one_q   <= `RST_CFG_ONE;   // RL13
         cfg_two_q   <= `RST_CFG_TWO;   // RL14
         cfg_three_q <= `RST_CFG_THREE; // RL15
         cfg_four_q  <= `RST_CFG_FOUR;  // RL16
      end else if (restore) begin
         status_one_nonvolatile_q <= `RST_STATUS_ONE; // RL12
         cfg_one_q   <= `RST_CFG_ONE;   // RL13
         cfg_two_q   <= `RST_CFG_TWO;   // RL14
         cfg_three_q <= `RST_CFG_THREE; // RL15
         cfg_four_q  <= `RST_CFG_FOUR;  // RL16
      end else begin
         if (wsel == SEL_STAT1) status_one_nonvolatile_q <= i_wdata[7:0];
         if (wsel == SEL_CFG1) cfg_one_q <= i_wdata[7:0];
         if (wsel == SEL_CFG2) cfg_two_q <= i_wdata[7:0];
         if (wsel == SEL_CFG3) cfg_three_q <= i_wdata[7:0];
         if (wsel == SEL_CFG4) cfg_four_q <= i_wdata[7:0];
      end
   end

   // Password, full overwrite by halves
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         password_q <= `RST_PASSWORD; // RL17
      end else if (restore) begin
         password_q <= `RST_PASSWORD; // RL17
      end else if (wsel == SEL_PASS_LO) begin
         password_q[31:0] <= i_wdata;
      end else if (wsel == SEL_PASS_HI) begin
         password_q[63:32] <= i_wdata;
      end
   end

   // Protection scheme bits only program from one to zero
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sector_protection_scheme_q <= `RST_SCHEME; // RL18
      end else if (restore) begin
         sector_protection_scheme_q <= `RST_SCHEME; // RL18
      end else if (wsel == SEL_SCHEME) begin
         sector_protection_scheme_q <= sector_protection_scheme_q & i_wdata[15:0];
      end
   end

   // Lock group pointer and one-time area pointer
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lock_index_q <= '0;
         otp_addr_q   <= '0;
      end else begin
         if (wsel == SEL_LOCK_IDX) lock_index_q <= i_wdata[LW-1:0];
         if (wsel == SEL_OTP_ADDR) otp_addr_q <= i_wdata[OW-1:0];
      end
   end

   // Sector lock bits: a write clears zeros in the group, erase sets all
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         persistent_sector_lock_bits_q <= '1; // RL19
      end else if (restore || lock_erase) begin
         persistent_sector_lock_bits_q <= '1; // RL19
      end else if (wsel == SEL_LOCK_DAT) begin
         persistent_sector_lock_bits_q[lock_index_q*32 +: 32] <=
            persistent_sector_lock_bits_q[lock_index_q*32 +: 32] & i_wdata;
      end
   end

   // One-time area: random head, erased tail, programming only clears bits
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < OTP_BYTES; i++) begin
            otp_q[i] <= (i < `OTP_RANDOM_BYTES) ? OTP_SEED[(i%16)*8 +: 8] : `ERASED_BYTE; // RL11
         end
      end else if (wsel == SEL_OTP_DAT) begin
         otp_q[otp_addr_q] <= otp_q[otp_addr_q] & i_wdata[7:0];
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = '0;
      unique case (rsel)
         SEL_MAP64:    rdata_d = map64_word;
         SEL_HDR256:   rdata_d = hdr256_word;
         SEL_MAP256:   rdata_d = map256_word;
         SEL_STAT1:    rdata_d[7:0] = status_one_nonvolatile_q;
         SEL_CFG1:     rdata_d[7:0] = cfg_one_q;
         SEL_CFG2:     rdata_d[7:0] = cfg_two_q;
         SEL_CFG3:     rdata_d[7:0] = cfg_three_q;
         SEL_CFG4:     rdata_d[7:0] = cfg_four_q;
         SEL_PASS_LO:  rdata_d = password_q[31:0];
         SEL_PASS_HI:  rdata_d = password_q[63:32];
         SEL_SCHEME:   rdata_d[15:0] = sector_protection_scheme_q;
         SEL_LOCK_IDX: rdata_d[LW-1:0] = lock_index_q;
         SEL_LOCK_DAT: rdata_d = persistent_sector_lock_bits_q[lock_index_q*32 +: 32];
         SEL_OTP_ADDR: rdata_d[OW-1:0] = otp_addr_q;
         SEL_OTP_DAT:  rdata_d[7:0] = otp_q[otp_addr_q];
         SEL_CTRL:     rdata_d = '0;
         SEL_STATE:    rdata_d[1:0] = {&persistent_sector_lock_bits_q, LARGE_DEVICE};
         SEL_ARRAY:    rdata_d[7:0] = `ERASED_BYTE; // RL10
         SEL_NONE:     rdata_d = '0;
      endcase
   end

   // Read data register, valid only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata  <= '0;
         o_rvalid <= 1'b0;
      end else begin
         o_rdata  <= i_rd ? rdata_d : '0;
         o_rvalid <= i_rd;
      end
   end

   // Helper state for the checks below
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         otp_touched_q <= 1'b0;
         first_seen_q  <= 1'b0;
      end else begin
         first_seen_q <= 1'b1;
         if (wsel == SEL_OTP_DAT) otp_touched_q <= 1'b1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   chk_small_size64: assert property ( // RL1
      (i_rd && i_addr == `OFS_MAP64_REGION && !LARGE_DEVICE)
      |=> (o_rdata[31:8] == 24'h00FFFF) && o_rvalid)
      else $error("64KB region size wrong on small device");

   chk_large_size64: assert property ( // RL2
      (i_rd && i_addr == `OFS_MAP64_REGION && LARGE_DEVICE)
      |=> (o_rdata[31:24] == 8'h01) && (o_rdata[31:8] == 24'h01FFFF))
      else $error("64KB region size wrong on large device");

   chk_erase_type64: assert property ( // RL3
      i_rd && i_addr == `OFS_MAP64_REGION |=> o_rdata[7:0] == 8'hF2)
      else $error("64KB region erase bits wrong");

   chk_hdr_id_count: assert property ( // RL4
      i_rd && i_addr == `OFS_MAP256_HDR |=> o_rdata[23:8] == 16'h0005)
      else $error("256KB header id or count wrong");

   chk_hdr_low_byte: assert property ( // RL5
      i_rd && i_addr == `OFS_MAP256_HDR |=> o_rdata[7:0] == 8'hFF)
      else $error("256KB header low byte wrong");

   chk_hdr_top_byte: assert property ( // RL6
      i_rd && i_addr == `OFS_MAP256_HDR ##1 o_rvalid |-> o_rdata[31:24] == 8'hFF)
      else $error("256KB header reserved byte wrong");

   chk_small_size256: assert property ( // RL7
      (i_rd && i_addr == `OFS_MAP256_REGION && !LARGE_DEVICE)
      |=> o_rdata[31:8] == 24'h00FFFF)
      else $error("256KB region size wrong on small device");

   chk_large_size256: assert property ( // RL8
      (i_rd && i_addr == `OFS_MAP256_REGION && LARGE_DEVICE)
      |=> o_rdata[31:8] == 24'h01FFFF)
      else $error("256KB region size wrong on large device");

   chk_erase_type256: assert property ( // RL9
      i_rd && i_addr == `OFS_MAP256_REGION |=> o_rdata[7:0] == 8'hF4)
      else $error("256KB region erase bits wrong");

   chk_array_erased: assert property ( // RL10
      i_rd && i_addr == `OFS_ARRAY_DATA |=> o_rdata == 32'h0000_00FF)
      else $error("Main array not erased");

   chk_otp_tail_erased: assert property ( // RL11
      (i_rd && i_addr == `OFS_OTP_DATA && !otp_touched_q
       && otp_addr_q >= OW'(`OTP_RANDOM_BYTES))
      |=> o_rdata[7:0] == 8'hFF)
      else $error("One-time tail not erased");

   chk_status_delivery: assert property ( // RL12
      !first_seen_q |-> status_one_nonvolatile_q == 8'h00)
      else $error("Status one delivery value wrong");

   chk_cfg_delivery: assert property ( // RL13
      !first_seen_q |-> cfg_one_q == 8'h00 && cfg_three_q == 8'h00) // RL15
      else $error("Configuration one or three delivery value wrong");

   chk_cfg_restore: assert property ( // RL14
      restore |=> cfg_two_q == 8'h08 && cfg_four_q == 8'h10 ##1 // RL16
      (cfg_two_q == 8'h08 || $past(wsel) == SEL_CFG2))
      else $error("Configuration two or four restore value wrong");

   chk_secret_delivery: assert property ( // RL17
      (!first_seen_q || $past(restore)) |-> &password_q && &sector_protection_scheme_q) // RL18
      else $error("Password or scheme delivery value wrong");

   // Sector lock bits after erase, reset and restore; a write at the first edge is legal
   chk_lock_erase: assert property ( // RL19
      lock_erase |=> &persistent_sector_lock_bits_q)
      else $error("Sector lock bits not all set after erase");

   chk_lock_delivery: assert property ( // RL19
      !first_seen_q |-> &persistent_sector_lock_bits_q)
      else $error("Sector lock bits not all set after reset");

   chk_lock_restore: assert property ( // RL19
      restore |=> &persistent_sector_lock_bits_q)
      else $error("Sector lock bits not all set after restore");

   // Restore brings back the delivered register copies
   chk_nv_restore: assert property ( // RL12
      restore |=> status_one_nonvolatile_q == 8'h00 && cfg_one_q == 8'h00 // RL13
      && cfg_three_q == 8'h00) // RL15
      else $error("Status one or configuration restore value wrong");

   // Untouched one-time head reads the factory random bytes
   chk_otp_head_random: assert property ( // RL11
      (i_rd && i_addr == `OFS_OTP_DATA && !otp_touched_q
       && otp_addr_q < OW'(`OTP_RANDOM_BYTES))
      |=> o_rdata[7:0] == OTP_SEED[otp_addr_q[3:0]*8 +: 8])
      else $error("One-time random head wrong");

   // Whole header word in one compare
   chk_hdr_whole_word: assert property ( // RL4
      (i_rd && i_addr == `OFS_MAP256_HDR) |=> o_rdata == 32'hFF00_05FF) // RL5 RL6
      else $error("256KB header word wrong");

   // Answer timing of the register bus
   chk_read_answer: assert property (
      i_rd |=> o_rvalid)
      else $error("Read answer missing");

   chk_read_idle: assert property (
      !i_rd |=> !o_rvalid && o_rdata == 32'h0)
      else $error("Read data not idle");

   // Protection scheme bits never return from zero to one by a write
   chk_scheme_clears: assert property (
      wsel == SEL_SCHEME
      |=> (sector_protection_scheme_q & ~$past(sector_protection_scheme_q)) == 16'h0)
      else $error("Protection scheme bit set by a write");

   cov_map_read: cover property (i_rd && i_addr == `OFS_MAP256_HDR ##1 o_rvalid);
   cov_otp_program: cover property (wsel == SEL_OTP_DAT ##1 i_rd && i_addr == `OFS_OTP_DATA);
   cov_restore: cover property (wsel == SEL_CFG2 ##[1:4] restore);
   cov_lock_erase: cover property (lock_erase ##[1:4] (i_rd && i_addr == `OFS_STATE));
   cov_otp_head: cover property (
      i_rd && i_addr == `OFS_OTP_DATA && otp_addr_q < OW'(`OTP_RANDOM_BYTES));

endmodule // sector_map_defaults

// [sector_map_defaults_params.svh]
// Offsets, field positions and delivery values of the parameter store
`ifndef SECTOR_MAP_DEFAULTS_PARAMS_SVH
`define SECTOR_MAP_DEFAULTS_PARAMS_SVH
`define OFS_MAP64_REGION  8'h00
`define OFS_MAP256_HDR    8'h04
`define OFS_MAP256_REGION 8'h08
`define OFS_STATUS_ONE    8'h0C
`define OFS_CFG_ONE       8'h10
`define OFS_CFG_TWO       8'h14
`define OFS_CFG_THREE     8'h18
`define OFS_CFG_FOUR      8'h1C
`define OFS_PASSWORD_LO   8'h20
`define OFS_PASSWORD_HI   8'h24
`define OFS_SCHEME        8'h28
`define OFS_LOCK_INDEX    8'h2C
`define OFS_LOCK_DATA     8'h30
`define OFS_OTP_ADDR      8'h34
`define OFS_OTP_DATA      8'h38
`define OFS_CONTROL       8'h3C
`define OFS_STATE         8'h40
`define OFS_ARRAY_DATA    8'h44
`define ERASE_T1_BIT      0
`define ERASE_T2_BIT      1
`define ERASE_T3_BIT      2
`define ERASE_T4_BIT      3
`define DESC_UPPER_NIB    4'hF
`define SIZE_SMALL_DEV    24'h00FFFF
`define SIZE_LARGE_DEV    24'h01FFFF
`define HDR_RESERVED      8'hFF
`define HDR_REGION_COUNT  8'h00
`define HDR_CONFIG_ID     8'h05
`define HDR_LOW_RESERVED  6'h3F
`define HDR_MAP_BIT       1
`define HDR_END_BIT       0
`define CTRL_RESTORE_BIT  0
`define CTRL_LOCK_ERASE   1
`define ERASED_BYTE       8'hFF
`define OTP_RANDOM_BYTES  16
`define RST_STATUS_ONE    8'h00
`define RST_CFG_ONE       8'h00
`define RST_CFG_TWO       8'h08
`define RST_CFG_THREE     8'h00
`define RST_CFG_FOUR      8'h10
`define RST_PASSWORD      64'hFFFF_FFFF_FFFF_FFFF
`define RST_SCHEME        16'hFFFF
`endif

// [sector_map_defaults_pkg.sv]
// Types shared by the parameter store
package sector_map_defaults_pkg;
   typedef logic [31:0] word_t;
   typedef logic [7:0]  byte_t;
   typedef enum logic [4:0] {
      SEL_MAP64    = 5'h00,
      SEL_HDR256   = 5'h01,
      SEL_MAP256   = 5'h02,
      SEL_STAT1    = 5'h03,
      SEL_CFG1     = 5'h04,
      SEL_CFG2     = 5'h05,
      SEL_CFG3     = 5'h06,
      SEL_CFG4     = 5'h07,
      SEL_PASS_LO  = 5'h08,
      SEL_PASS_HI  = 5'h09,
      SEL_SCHEME   = 5'h0A,
      SEL_LOCK_IDX = 5'h0B,
      SEL_LOCK_DAT = 5'h0C,
      SEL_OTP_ADDR = 5'h0D,
      SEL_OTP_DAT  = 5'h0E,
      SEL_CTRL     = 5'h0F,
      SEL_STATE    = 5'h10,
      SEL_ARRAY    = 5'h11,
      SEL_NONE     = 5'h1F
   } reg_sel_t;
endpackage

// [host_bus_model.sv]
// Host controller model that drives the register bus of the parameter store
`timescale 1ns/1ps

module host_bus_model (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_rdata_s,
   input  wire logic [31:0] i_rdata_l,
   input  wire logic        i_rvalid,
   output logic      [7:0]  o_addr,
   output logic      [31:0] o_wdata,
   output logic             o_wr,
   output logic             o_rd
);
   // Idle bus from time zero
   initial begin
      o_addr  = 8'h00;
      o_wdata = 32'h0000_0000;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end

   // One-cycle write; released fields show inverted values, never stale ones
   task automatic write(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_wr    <= 1'b1;
      o_addr  <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
   endtask

   // One-cycle read; the answer stands only in the cycle after the strobe
   task automatic read(input logic [7:0] a, output logic [31:0] ds,
                       output logic [31:0] dl, output logic v);
      @(posedge i_clk);
      o_rd   <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd   <= 1'b0;
      o_addr <= ~a;
      #1;
      ds = i_rdata_s;
      dl = i_rdata_l;
      v  = i_rvalid;
   endtask
endmodule // host_bus_model

// [tb.sv]
// Self-checking bench for the sector map tail and delivery state store
`timescale 1ns/1ps

module tb;
   import sector_map_defaults_pkg::*;
   // Arbitrary content for the random head of the one-time area
   localparam logic [127:0] SEED = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;

   logic        i_clk;
   logic        i_reset_n;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata_s;
   logic [31:0] rdata_l;
   logic        rvalid_s;
   logic        rvalid_l;
   int          errors;
   int          n_compared;

   // Small device and large device share one bus
   sector_map_defaults #(.LARGE_DEVICE(1'b0), .OTP_SEED(SEED)) i_dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata_s), .o_rvalid(rvalid_s));
   sector_map_defaults #(.LARGE_DEVICE(1'b1), .OTP_SEED(SEED)) i_dut_large (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata_l), .o_rvalid(rvalid_l));
   host_bus_model i_host (
      .i_clk(i_clk), .i_rdata_s(rdata_s), .i_rdata_l(rdata_l),
      .i_rvalid(rvalid_s & rvalid_l), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd));

   // 25 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // Compare one value and count it
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Read one address from both devices, then see the answer drop again
   task automatic rd_both(input logic [7:0] a, input logic [31:0] es, input logic [31:0] el);
      logic [31:0] ds, dl;
      logic        v;
      i_host.read(a, ds, dl, v);
      check($sformatf("small read %h", a), es, ds);
      check($sformatf("large read %h", a), el, dl);
      check("read valid", 32'h1, {31'h0, v});
      @(posedge i_clk);
      #1;
      check("idle read data", 32'h0, rdata_s | rdata_l);
      check("idle read valid", 32'h0, {31'h0, rvalid_s | rvalid_l});
   endtask

   // Whole delivery state as seen after reset or restore
   task automatic defaults();
      logic [7:0] b;
      rd_both(8'h0C, 32'h0000_0000, 32'h0000_0000);
      rd_both(8'h10, 32'h0000_0000, 32'h0000_0000);
      rd_both(8'h14, 32'h0000_0008, 32'h0000_0008);
      rd_both(8'h18, 32'h0000_0000, 32'h0000_0000);
      rd_both(8'h1C, 32'h0000_0010, 32'h0000_0010);
      rd_both(8'h20, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      rd_both(8'h24, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      rd_both(8'h28, 32'h0000_FFFF, 32'h0000_FFFF);
      rd_both(8'h44, 32'h0000_00FF, 32'h0000_00FF);
      rd_both(8'h40, 32'h0000_0002, 32'h0000_0003);
      // Every lock group of 32 sectors
      for (int g = 0; g < 8; g++) begin
         i_host.write(8'h2C, 32'(g));
         rd_both(8'h30, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      end
      // Random head, first erased bytes and the last byte of the one-time area
      for (int i = 0; i < 19; i++) begin
         b = (i < 16) ? SEED[i*8 +: 8] : 8'hFF;
         i_host.write(8'h34, (i == 18) ? 32'h0000_03FF : 32'(i));
         rd_both(8'h38, {24'h0, b}, {24'h0, b});
      end
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clk);
      errors++;
      $display("unexpected run length: expected finish seen timeout");
      test_done();
   end

   // Main sequence
   initial begin
      errors     = 0;
      n_compared = 0;
      i_reset_n  = 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      // Sector map tail descriptors, small then large device
      rd_both(8'h00, 32'h00FF_FFF2, 32'h01FF_FFF2);
      rd_both(8'h04, 32'hFF00_05FF, 32'hFF00_05FF);
      rd_both(8'h08, 32'h00FF_FFF4, 32'h01FF_FFF4);
      // Descriptors cannot be overwritten
      i_host.write(8'h04, 32'h0000_0000);
      i_host.write(8'h08, 32'h0000_0000);
      rd_both(8'h04, 32'hFF00_05FF, 32'hFF00_05FF);
      rd_both(8'h08, 32'h00FF_FFF4, 32'h01FF_FFF4);
      rd_both(8'h80, 32'h0000_0000, 32'h0000_0000);
      defaults();
      // Change the state, then restore delivery values
      i_host.write(8'h14, 32'h0000_0055);
      rd_both(8'h14, 32'h0000_0055, 32'h0000_0055);
      i_host.write(8'h28, 32'h0000_0F0F);
      i_host.write(8'h28, 32'h0000_FF00);
      rd_both(8'h28, 32'h0000_0F00, 32'h0000_0F00);
      i_host.write(8'h20, 32'h1234_5678);
      i_host.write(8'h24, 32'h9ABC_DEF0);
      i_host.write(8'h0C, 32'h0000_005A);
      rd_both(8'h20, 32'h1234_5678, 32'h1234_5678);
      rd_both(8'h24, 32'h9ABC_DEF0, 32'h9ABC_DEF0);
      rd_both(8'h0C, 32'h0000_005A, 32'h0000_005A);
      i_host.write(8'h2C, 32'h0000_0002);
      rd_both(8'h2C, 32'h0000_0002, 32'h0000_0002);
      i_host.write(8'h30, 32'h0000_0000);
      rd_both(8'h30, 32'h0000_0000, 32'h0000_0000);
      rd_both(8'h40, 32'h0000_0000, 32'h0000_0001);
      i_host.write(8'h3C, 32'h0000_0002);
      rd_both(8'h40, 32'h0000_0002, 32'h0000_0003);
      i_host.write(8'h30, 32'h0000_0000);
      i_host.write(8'h34, 32'h0000_0014);
      i_host.write(8'h38, 32'h0000_00A5);
      rd_both(8'h3C, 32'h0000_0000, 32'h0000_0000);
      i_host.write(8'h3C, 32'h0000_0001);
      defaults();
      // Programmed one-time byte survives the restore
      i_host.write(8'h34, 32'h0000_0014);
      rd_both(8'h38, 32'h0000_00A5, 32'h0000_00A5);
      rd_both(8'h34, 32'h0000_0014, 32'h0000_0014);
      // Reset in mid-run reloads the delivery state
      i_host.write(8'h1C, 32'h0000_00AA);
      rd_both(8'h1C, 32'h0000_00AA, 32'h0000_00AA);
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      defaults();
      rd_both(8'h00, 32'h00FF_FFF2, 32'h01FF_FFF2);
      test_done();
   end

   // Verdict and end of run
   task automatic test_done();
      if (errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
endmodule // tb
